// ---- hw/video_lane_receiver_window_ctrl.sv ----
// Purpose: Video lane receiver with pixel unpacking and window placement
// Assumes: Register port is the internal side of the serial interface
// Notes: Pixels leave with array addresses and an in-window mask
`timescale 1ns/1ps

module video_lane_receiver_window_ctrl #(
	parameter int DELAY_CYCLES = video_rx_pkg::POS_DELAY_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [16:0] laneData,
	input wire logic laneClk,
	input wire logic alignIn,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdData,
	output video_rx_pkg::pixel_type [3:0] pixOut,
	output logic [3:0] pixMask,
	output logic pixValid,
	output logic pixVsync,
	output logic pixHsync,
	output logic [11:0] pixCol,
	output logic [11:0] pixRow,
	output logic quadOut
);

	localparam logic [20:0] DELAY_LAST = 21'(DELAY_CYCLES - 1);

	video_rx_pkg::rx_state_type s;
	video_rx_pkg::rx_state_type next_s;
	video_rx_pkg::lane_word_type laneWord;
	logic wordValid;
	logic aligned;

	// Edge register index, shared by write and read decoding
	function automatic logic [3:0] edgeIndex(input logic [7:0] addr);
		logic [7:0] rel;
		rel = 8'h00;
		if (addr >= video_rx_pkg::QUAD_WINDOW_BASE_OFS) begin
			rel = addr - video_rx_pkg::QUAD_WINDOW_BASE_OFS + 8'h08;
		end else begin
			rel = addr - video_rx_pkg::WINDOW_BASE_OFS;
		end
		return rel[3:0];
	endfunction

	function automatic logic isEdge(input logic [7:0] addr);
		return (addr >= video_rx_pkg::WINDOW_BASE_OFS &&
			addr < video_rx_pkg::WINDOW_BASE_OFS +
			video_rx_pkg::EDGE_BYTES) ||
			(addr >= video_rx_pkg::QUAD_WINDOW_BASE_OFS &&
			addr < video_rx_pkg::QUAD_WINDOW_BASE_OFS +
			video_rx_pkg::EDGE_BYTES);
	endfunction

	// Stretch a span that is too small, staying inside the array;
	// returns {lo, hi} so the reset windows can be folded at elaboration
	function automatic logic [23:0] fixSpan(input logic [11:0] loIn,
			input logic [11:0] hiIn, input logic [11:0] span);
		logic [11:0] lo;
		logic [11:0] hi;
		lo = loIn;
		hi = hiIn;
		if (hi < lo + span) begin
			hi = lo + span; // RULE14 RULE19
		end
		if (hi > video_rx_pkg::ARRAY_LAST) begin
			hi = video_rx_pkg::ARRAY_LAST; // RULE16
			if (lo > hi - span) begin
				lo = hi - span;
			end
		end
		return {lo, hi};
	endfunction

	// Four twelve-bit edges from eight bytes, low byte first
	function automatic video_rx_pkg::window_type buildWindow(
			input logic [15:0][7:0] b, input int base,
			input logic [11:0] span);
		video_rx_pkg::window_type w;
		logic [11:0] l;
		logic [11:0] r;
		logic [11:0] t;
		logic [11:0] m;
		l = {b[base+1][3:0], b[base]};
		r = {b[base+3][3:0], b[base+2]};
		t = {b[base+5][3:0], b[base+4]};
		m = {b[base+7][3:0], b[base+6]};
		{l, r} = fixSpan(l, r, span);
		{t, m} = fixSpan(t, m, span);
		w.left = l;
		w.right = r;
		w.top = t;
		w.bottom = m;
		return w;
	endfunction

	// One pixel from four consecutive lanes; the highest lane of the
	// group carries red, bit 5 of each lane first
	function automatic video_rx_pkg::pixel_type unpack(
			input video_rx_pkg::lane_word_type w, input int b);
		video_rx_pkg::pixel_type p;
		p.red = {w[b+3], w[b+2][5:4]}; // RULE10
		p.green = {w[b+2][3:0], w[b+1][5:2]};
		p.blue = {w[b+1][1:0], w[b]};
		return p;
	endfunction

	function automatic logic [2:0] pixelsPerWord(input logic [1:0] mode);
		case (mode)
			video_rx_pkg::MODE_QUAD: return 3'h4;
			video_rx_pkg::MODE_DUAL: return 3'h2;
			default: return 3'h1;
		endcase
	endfunction

	// Shared window edges as the reset state of the applied windows
	localparam video_rx_pkg::window_type NORM_RST = buildWindow(
		video_rx_pkg::EDGE_BYTES_RST, 0, video_rx_pkg::MIN_SPAN);
	localparam video_rx_pkg::window_type QUAD_RST = buildWindow(
		video_rx_pkg::EDGE_BYTES_RST, 8, video_rx_pkg::QUAD_MIN_SPAN);

	lane_deserializer u_deser (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.laneClk(s.syncStable[17]),
		.laneBits(s.syncStable[16:0]),
		.alignLevel(s.syncStable[18]),
		.laneWord(laneWord),
		.wordValid(wordValid),
		.aligned(aligned)
	); // RULE1

	always_comb begin
		video_rx_pkg::window_type win;
		logic quadEn;
		logic blank;
		logic setPending;
		logic vs;
		logic hs;
		logic de;
		logic [2:0] ppw;
		logic [11:0] widthPix;
		logic [11:0] heightPix;
		logic [11:0] colOff;
		logic [11:0] rowOff;
		logic [11:0] k12;
		video_rx_pkg::pixel_type [3:0] px;
		next_s = s;
		win = s.normWin;
		quadEn = s.linkControl[video_rx_pkg::QUAD_EN_POS];
		blank = s.displayMode[video_rx_pkg::DISPLAY_BLANK_POS];
		setPending = 1'b0;
		vs = laneWord[video_rx_pkg::SYNC_LANE][video_rx_pkg::VSYNC_BIT];
		hs = laneWord[video_rx_pkg::SYNC_LANE][video_rx_pkg::HSYNC_BIT];
		de = laneWord[video_rx_pkg::SYNC_LANE][video_rx_pkg::VALID_BIT];
		ppw = pixelsPerWord(s.inputMode);
		px = '0;
		k12 = 12'h000;
		widthPix = 12'h000;
		heightPix = 12'h000;
		colOff = 12'h000;
		rowOff = 12'h000;

		// Two-flop synchroniser for every link pin
		next_s.syncMeta = {alignIn, laneClk, laneData};
		next_s.syncStable = s.syncMeta;

		// Register writes; mode bits act at once, edges wait for the timer
		if (regWrite) begin
			case (regAddr)
				video_rx_pkg::INPUT_MODE_OFS: begin
					next_s.inputMode = regWrData[1:0]; // RULE9
				end
				video_rx_pkg::DISPLAY_MODE_OFS: begin
					next_s.displayMode = regWrData; // RULE7 RULE8
				end
				video_rx_pkg::LINK_CONTROL_OFS: begin
					next_s.linkControl = regWrData; // RULE20
				end
				default: begin
					if (isEdge(regAddr)) begin
						next_s.edgeBytes[edgeIndex(regAddr)] = regWrData;
						setPending = 1'b1; // RULE13 RULE21
					end
				end
			endcase
		end

		// Read data captured one cycle after the strobe
		if (regRead) begin
			case (regAddr)
				video_rx_pkg::INPUT_MODE_OFS: begin
					next_s.rdData = {6'h00, s.inputMode};
				end
				video_rx_pkg::DISPLAY_MODE_OFS: next_s.rdData = s.displayMode;
				video_rx_pkg::LINK_CONTROL_OFS: next_s.rdData = s.linkControl;
				video_rx_pkg::STATUS_OFS: begin
					next_s.rdData = 8'h00;
					next_s.rdData[video_rx_pkg::STATUS_ALIGNED_POS] = aligned;
					next_s.rdData[video_rx_pkg::STATUS_PENDING_POS] =
						s.pending;
				end
				default: begin
					if (isEdge(regAddr)) begin
						next_s.rdData = s.edgeBytes[edgeIndex(regAddr)];
					end else begin
						next_s.rdData = 8'h00;
					end
				end
			endcase
		end

		// Free-running update timer: edge writes pending at an expiry land together,
		// at most once per period; a burst that spans an expiry lands in two steps
		if (s.delayCount == 21'h00000) begin
			next_s.delayCount = DELAY_LAST;
			if (s.pending) begin
				next_s.normWin = buildWindow(s.edgeBytes, 0,
					video_rx_pkg::MIN_SPAN); // RULE17
				next_s.quadWin = buildWindow(s.edgeBytes, 8,
					video_rx_pkg::QUAD_MIN_SPAN);
				next_s.pending = 1'b0;
			end
		end else begin
			next_s.delayCount = s.delayCount - 21'h00001;
		end
		if (setPending) begin
			next_s.pending = 1'b1; // A write beats a same-cycle apply
		end

		// Window in input pixels for the selected mode
		if (quadEn) begin
			win = s.quadWin; // RULE21
			widthPix = 12'((win.right - win.left + 12'h001) >> 1);
			heightPix = 12'((win.bottom - win.top + 12'h001) >> 1);
			if (widthPix > video_rx_pkg::QUAD_MAX_COLS) begin
				widthPix = video_rx_pkg::QUAD_MAX_COLS; // RULE18
			end
			if (heightPix > video_rx_pkg::QUAD_MAX_ROWS) begin
				heightPix = video_rx_pkg::QUAD_MAX_ROWS;
			end
		end else begin
			widthPix = win.right - win.left + 12'h001;
			heightPix = win.bottom - win.top + 12'h001;
		end

		// Slot unpacking; slots the mode does not use stay zero
		px[0] = unpack(laneWord, video_rx_pkg::PIX0_LANE);
		if (ppw != 3'h1) begin
			px[1] = unpack(laneWord, video_rx_pkg::PIX1_LANE); // RULE22
		end
		if (ppw == 3'h4) begin
			px[2] = unpack(laneWord, video_rx_pkg::PIX2_LANE); // RULE12
			px[3] = unpack(laneWord, video_rx_pkg::PIX3_LANE);
		end

		// Word-rate sequencing driven by the sync lane
		next_s.pixValid = 1'b0;
		if (wordValid) begin
			next_s.pixVsync = vs; // RULE11
			next_s.pixHsync = hs;
			next_s.prevVsync = vs;
			next_s.prevValid = de;
			if (vs && !s.prevVsync) begin
				next_s.rowIdx = 12'h000;
				next_s.colIdx = 12'h000;
			end else if (!de && s.prevValid) begin
				next_s.colIdx = 12'h000;
				if (s.rowIdx != 12'hfff) begin
					next_s.rowIdx = s.rowIdx + 12'h001;
				end
			end
			if (de) begin
				next_s.pixValid = 1'b1; // RULE6
				next_s.quadOut = quadEn;
				colOff = quadEn ? {s.colIdx[10:0], 1'b0} : s.colIdx;
				rowOff = quadEn ? {s.rowIdx[10:0], 1'b0} : s.rowIdx;
				next_s.pixCol = s.displayMode[
					video_rx_pkg::HORIZONTAL_DIR_POS] ?
					win.right - colOff : win.left + colOff; // RULE8
				next_s.pixRow = s.displayMode[
					video_rx_pkg::VERTICAL_DIR_POS] ?
					win.bottom - rowOff : win.top + rowOff;
				for (int k = 0; k < 4; k++) begin
					k12 = 12'(k);
					// Outside the window or while blanked the pixel is black
					if (!blank && k12 < 12'(ppw) &&
							s.colIdx + k12 < widthPix &&
							s.rowIdx < heightPix) begin // RULE15 RULE7
						next_s.pixMask[k] = 1'b1;
						next_s.pixOut[k] = px[k];
					end else begin
						next_s.pixMask[k] = 1'b0;
						next_s.pixOut[k] = '0;
					end
				end
				next_s.colIdx = s.colIdx + 12'(ppw);
			end
		end
	end

	// Single state register
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			s <= '0;
			s.inputMode <= video_rx_pkg::INPUT_MODE_RST;
			s.displayMode <= video_rx_pkg::DISPLAY_MODE_RST;
			s.linkControl <= video_rx_pkg::LINK_CONTROL_RST;
			s.edgeBytes <= video_rx_pkg::EDGE_BYTES_RST;
			s.normWin <= NORM_RST;
			s.quadWin <= QUAD_RST;
		end else begin
			s <= next_s;
		end
	end

	assign regRdData = s.rdData;
	assign pixOut = s.pixOut;
	assign pixMask = s.pixMask;
	assign pixValid = s.pixValid;
	assign pixVsync = s.pixVsync;
	assign pixHsync = s.pixHsync;
	assign pixCol = s.pixCol;
	assign pixRow = s.pixRow;
	assign quadOut = s.quadOut;

endmodule // video_lane_receiver_window_ctrl

// ---- hw/video_rx_pkg.sv ----
// Purpose: Shared constants and carrier types for the video lane receiver
// Assumes: 100 MHz ref_clk; lane inputs are asynchronous to it
// Notes: Register offsets are byte addresses on the serial register port
//
// What this block does
// RULE1: Link is 17 data lanes, one clock lane, one CMOS align input.
// RULE2: Source sends six bits per lane for every word.
// RULE3: Clock lane toggles like data; quad rate is 3/4 pixel clock.
// RULE4: Receiver samples lane data on both edges of the lane clock.
// RULE5: Align patterns on lane 7 mark the MSB of each six-bit group.
// RULE6: Sequencer controls come from mode and four window-edge registers.
// RULE7: Array stays black after reset until the blank bit is cleared.
// RULE8: Vertical and horizontal direction bits reverse the scan order.
// RULE9: Input mode low two bits pick quad, dual or single pixel mode.
// RULE10: Each pixel spans four lanes, bit 5 first, RGB packed in order.
// RULE11: Lane 8 carries vsync bit 5, hsync bit 3, pixel valid bit 1.
// RULE12: Quad pixels come from lanes 4-7, 9-12, 0-3, 13-16.
// RULE13: Left, right, top, bottom edge registers set the active window.
// RULE14: Windows smaller than 512 by 512 are widened to 512 by 512.
// RULE15: Every array pixel outside the active window is driven black.
// RULE16: Window lies inside the 2072 by 2072 addressable array.
// RULE17: Window position changes apply through a 16 ms update delay.
// RULE18: Quadrupling doubles rows and columns; input up to 1036 by 1236.
// RULE19: Doubled window is never smaller than 1024 by 1024 array pixels.
// RULE20: Bit 6 of link control at 03h enables pixel quadrupling.
// RULE21: Quadrupling takes its edges from registers 1Ah through 21h.
// RULE22: Dual and single modes ignore unused lanes.

package video_rx_pkg;

	// Link shape
	localparam int NUM_LANES = 17;
	localparam int LANE_BITS = 6;
	localparam int ALIGN_LANE = 7;
	localparam int SYNC_LANE = 8;
	localparam int VSYNC_BIT = 5;
	localparam int HSYNC_BIT = 3;
	localparam int VALID_BIT = 1;
	localparam logic [5:0] ALIGN_PATTERN = 6'h38;

	// Lane groups of each pixel slot
	localparam int PIX0_LANE = 4;
	localparam int PIX1_LANE = 9;
	localparam int PIX2_LANE = 0;
	localparam int PIX3_LANE = 13;

	// Array geometry
	localparam logic [11:0] ARRAY_LAST = 12'h817;
	localparam logic [11:0] MIN_SPAN = 12'h1ff;
	localparam logic [11:0] QUAD_MIN_SPAN = 12'h3ff;
	localparam logic [11:0] QUAD_MAX_COLS = 12'h40c;
	localparam logic [11:0] QUAD_MAX_ROWS = 12'h4d4;

	// Register offsets
	localparam logic [7:0] INPUT_MODE_OFS = 8'h00;
	localparam logic [7:0] DISPLAY_MODE_OFS = 8'h01;
	localparam logic [7:0] LINK_CONTROL_OFS = 8'h03;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] WINDOW_BASE_OFS = 8'h10;
	localparam logic [7:0] QUAD_WINDOW_BASE_OFS = 8'h1a;
	localparam logic [7:0] EDGE_BYTES = 8'h08;

	// Field positions
	localparam int DISPLAY_BLANK_POS = 0;
	localparam int VERTICAL_DIR_POS = 1;
	localparam int HORIZONTAL_DIR_POS = 2;
	localparam int QUAD_EN_POS = 6;
	localparam int STATUS_ALIGNED_POS = 0;
	localparam int STATUS_PENDING_POS = 1;

	// Reset values
	localparam logic [1:0] INPUT_MODE_RST = 2'h1;
	localparam logic [7:0] DISPLAY_MODE_RST = 8'h01;
	localparam logic [7:0] LINK_CONTROL_RST = 8'h00;
	localparam logic [127:0] EDGE_BYTES_RST =
		128'h04d3_0000_040b_0000_0817_0000_0817_0000;

	// Timing
	localparam int REF_CLK_MHZ = 100;
	localparam int POS_DELAY_MS = 16;
	localparam int POS_DELAY_CYCLES = POS_DELAY_MS * 1000 * REF_CLK_MHZ;

	typedef enum logic [1:0] {
		MODE_DUAL = 2'b00,
		MODE_QUAD = 2'b01,
		MODE_SINGLE = 2'b10,
		MODE_SINGLE_ALT = 2'b11
	} input_mode_type;

	typedef logic [NUM_LANES-1:0][LANE_BITS-1:0] lane_word_type;

	typedef struct packed {
		logic [7:0] red;
		logic [7:0] green;
		logic [7:0] blue;
	} pixel_type;

	typedef struct packed {
		logic [11:0] left;
		logic [11:0] right;
		logic [11:0] top;
		logic [11:0] bottom;
	} window_type;

	typedef struct packed {
		logic prevClk;
		logic [2:0] bitCount;
		lane_word_type shift;
		lane_word_type word;
		logic wordValid;
		logic aligned;
	} deser_state_type;

	typedef struct packed {
		logic [NUM_LANES+1:0] syncMeta;
		logic [NUM_LANES+1:0] syncStable;
		logic [1:0] inputMode;
		logic [7:0] displayMode;
		logic [7:0] linkControl;
		logic [15:0][7:0] edgeBytes;
		window_type normWin;
		window_type quadWin;
		logic pending;
		logic [20:0] delayCount;
		logic [7:0] rdData;
		logic [11:0] colIdx;
		logic [11:0] rowIdx;
		logic prevValid;
		logic prevVsync;
		pixel_type [3:0] pixOut;
		logic [3:0] pixMask;
		logic pixValid;
		logic pixVsync;
		logic pixHsync;
		logic [11:0] pixCol;
		logic [11:0] pixRow;
		logic quadOut;
	} rx_state_type;

endpackage

// ---- hw/lane_deserializer.sv ----
// Purpose: Double-edge capture of the synchronised lanes into six-bit words
// Assumes: Inputs already pass two flip-flops on ref_clk
// Notes: Link clock must be well below ref_clk/4 so each edge is seen
`timescale 1ns/1ps

module lane_deserializer (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic laneClk,
	input wire logic [video_rx_pkg::NUM_LANES-1:0] laneBits,
	input wire logic alignLevel,
	output video_rx_pkg::lane_word_type laneWord,
	output logic wordValid,
	output logic aligned
);

	video_rx_pkg::deser_state_type s;
	video_rx_pkg::deser_state_type next_s;
	video_rx_pkg::lane_word_type shifted;

	// Every lane clock edge, either direction, clocks one bit in
	always_comb begin
		next_s = s;
		shifted = s.shift;
		next_s.prevClk = laneClk;
		next_s.wordValid = 1'b0;
		if (laneClk != s.prevClk) begin // RULE4
			for (int i = 0; i < video_rx_pkg::NUM_LANES; i++) begin
				shifted[i] = {s.shift[i][4:0], laneBits[i]}; // RULE2
			end
			next_s.shift = shifted;
			// Pattern hit realigns the word boundary; the pattern itself
			// is not data, so no word leaves on that edge
			if (alignLevel && shifted[video_rx_pkg::ALIGN_LANE] ==
					video_rx_pkg::ALIGN_PATTERN) begin // RULE5
				next_s.bitCount = 3'h0;
				next_s.aligned = 1'b1;
			end else if (s.bitCount == 3'h5) begin
				next_s.bitCount = 3'h0;
				next_s.word = shifted;
				next_s.wordValid = 1'b1;
			end else begin
				next_s.bitCount = s.bitCount + 3'h1;
			end
		end
	end

	// Single state register
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign laneWord = s.word;
	assign wordValid = s.wordValid;
	assign aligned = s.aligned;

endmodule // lane_deserializer

// ---- verification/video_source_model.sv ----
// Purpose: Video source model driving the serial data and clock lanes
// Assumes: Bench calls sendWord; link clock stands still between words
// Notes: Released lanes show inverted bits so stale data never matches
`timescale 1ns/1ps

module video_source_model (
	output logic [16:0] laneData,
	output logic laneClk,
	output logic alignIn
);
	initial begin
		laneData = 17'h0;
		laneClk = 1'b0;
		alignIn = 1'b0;
	end

	// Six bits per lane, bit 5 first, one bit per link clock edge
	task automatic sendWord(input video_rx_pkg::lane_word_type w,
		input logic al);
		alignIn = al;
		for (int b = 5; b >= 0; b--) begin
			for (int i = 0; i < 17; i++)
				laneData[i] = w[i][b];
			#20;
			laneClk = ~laneClk;
			#20;
		end
		// Data is set up half a bit ahead of each edge for clean capture
		laneData = ~laneData;
		alignIn = 1'b0;
	endtask
endmodule // video_source_model

// ---- verification/video_lane_receiver_window_ctrl_assertions.sv ----
// Purpose: Port-level checks of the video lane receiver
// Assumes: Mode register writes are mirrored here
// Notes: Bound into every receiver instance
`timescale 1ns/1ps

module video_lane_receiver_window_ctrl_assertions #(
	parameter int DELAY_CYCLES = video_rx_pkg::POS_DELAY_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regRdData,
	input wire video_rx_pkg::pixel_type [3:0] pixOut,
	input wire logic [3:0] pixMask,
	input wire logic pixValid,
	input wire logic [11:0] pixCol,
	input wire logic [11:0] pixRow,
	input wire logic quadOut
);
	logic blank, quadEn;
	logic [1:0] mode;

	// Mirror follows writes at once; outputs lag one ref_clk edge, hence $past
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			blank <= 1'b1;
			mode <= 2'b01;
			quadEn <= 1'b0;
		end else if (regWrite) begin
			if (regAddr == 8'h01)
				blank <= regWrData[0];
			if (regAddr == 8'h00)
				mode <= regWrData[1:0];
			if (regAddr == 8'h03)
				quadEn <= regWrData[6];
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	unmapped_read_a: assert property (
		regRead && regAddr > 8'h21 |=> regRdData == 8'h00)
		else $error("unmapped read returned data");
	read_hold_a: assert property (
		!regRead |=> $stable(regRdData))
		else $error("read data moved without a read");
	valid_pulse_a: assert property (
		pixValid |=> !pixValid [*8])
		else $error("pixel valid too long or too close");
	blank_dark_a: assert property (
		pixValid && $past(blank) |-> pixMask == 4'h0)
		else $error("lit pixel while display blanked");
	dual_slots_a: assert property (
		pixValid && $past(mode) == 2'b00 |->
		pixMask[3:2] == 2'h0 && pixOut[3:2] == 48'h0)
		else $error("dual mode used upper slots");
	single_slot_a: assert property (
		pixValid && $past(mode[1]) |->
		pixMask[3:1] == 3'h0 && pixOut[3:1] == 72'h0)
		else $error("single mode used extra slots");
	quad_flag_a: assert property (
		pixValid |-> quadOut == $past(quadEn))
		else $error("quadrupling flag wrong");
	array_bound_a: assert property (
		pixValid |-> pixCol <= 12'h817 && pixRow <= 12'h817)
		else $error("address beyond array");
	pending_set_a: assert property (
		regWrite && regAddr[7:3] == 5'h02 ##1 regRead && regAddr == 8'h04
		|=> regRdData[1])
		else $error("edge write not pending");
endmodule // video_lane_receiver_window_ctrl_assertions

bind video_lane_receiver_window_ctrl
	video_lane_receiver_window_ctrl_assertions #(.DELAY_CYCLES(DELAY_CYCLES))
	chk_i (.ref_clk, .rst_b, .regAddr, .regWrData, .regWrite, .regRead,
	.regRdData, .pixOut, .pixMask, .pixValid, .pixCol, .pixRow, .quadOut);

// ---- verification/video_lane_receiver_window_ctrl_bench.sv ----
// Purpose: Self-checking bench for the video lane receiver
// Assumes: Source model runs an 80 ns link clock inside words only
// Notes: Edge update delay shortened to 64 cycles
`timescale 1ns/1ps

module video_lane_receiver_window_ctrl_bench;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWrData = 8'h00;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [7:0] regRdData;
	video_rx_pkg::pixel_type [3:0] pixOut;
	logic [3:0] pixMask;
	logic pixValid, pixVsync, pixHsync, quadOut, laneClk, alignIn;
	logic [11:0] pixCol, pixRow;
	logic [16:0] laneData;
	logic [31:0] rng = 32'h00004a0d;
	logic [15:0] rdTable[7] = '{16'h0001, 16'h0101, 16'h0300, 16'h4000,
		16'h1000, 16'h1217, 16'h1308};
	int laneBase[4] = '{4, 9, 0, 13};
	int fails = 0;
	int cmp_count = 0;
	int seen = 0;
	// Reference model state
	int col, blank, hdir, vdir, mode, q, lft, rgt;

	always #5 ref_clk = ~ref_clk;

	video_lane_receiver_window_ctrl #(.DELAY_CYCLES(64))
		video_lane_receiver_window_ctrl_i (.ref_clk, .rst_b, .laneData,
		.laneClk, .alignIn, .regAddr, .regWrData, .regWrite, .regRead,
		.regRdData, .pixOut, .pixMask, .pixValid, .pixVsync, .pixHsync,
		.pixCol, .pixRow, .quadOut);
	video_source_model video_source_model_i (.laneData, .laneClk, .alignIn);

	// Count result pulses; outputs then hold until the next word
	always @(posedge ref_clk)
		if (pixValid === 1'b1)
			seen <= seen + 1;

	function automatic logic [31:0] nxt();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction

	task automatic chk(input logic [95:0] e, s, input string n);
		cmp_count++;
		if (s !== e) begin
			fails++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask

	// A write leaves the strobe up; the next read lowers it
	task automatic wr(input logic [7:0] a, d);
		@(posedge ref_clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWrData <= d;
	endtask

	task automatic rd(input logic [7:0] a, e);
		@(posedge ref_clk);
		regWrite <= 1'b0;
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRead <= 1'b0;
		#1 chk(e, regRdData, "regRdData");
	endtask

	// Send one random word; valid words are compared with the model
	task automatic word(input logic [5:0] ctl);
		video_rx_pkg::lane_word_type w;
		logic [95:0] ep;
		logic [3:0] em;
		int s0, off, wid, p;
		w = 102'({nxt(), nxt(), nxt(), nxt()});
		w[8] = ctl;
		s0 = seen;
		p = mode == 1 ? 4 : (mode == 0 ? 2 : 1);
		video_source_model_i.sendWord(w, 1'b0);
		for (int t = 0; t < 12 && seen == s0; t++)
			@(posedge ref_clk);
		#1 chk(s0 + ctl[1], seen, "pixValid");
		if (ctl[1]) begin
			off = q ? 2 * col : col;
			wid = q ? (rgt - lft + 1) / 2 : rgt - lft + 1;
			if (q && wid > 1036)
				wid = 1036;
			for (int k = 0; k < 4; k++) begin
				// Forced-black slots carry zero data as well
				em[k] = !blank && k < p && col + k < wid;
				ep[24*k +: 24] = em[k] ? w[laneBase[k] +: 4] : 24'h0;
			end
			chk(ep, pixOut, "pixOut");
			chk(em, pixMask, "pixMask");
			chk(hdir ? rgt - off : lft + off, pixCol, "pixCol");
			chk(vdir ? 2071 : 0, pixRow, "pixRow");
			chk({q[0], 2'b01}, {quadOut, pixVsync, pixHsync}, "flags");
			col += p;
		end
	endtask

	// One line: vsync word, n valid words, then an idle word
	task automatic frame(input int n);
		word(6'h20);
		col = 0;
		repeat (n) word(6'h0a);
		word(6'h00);
	endtask

	task automatic end_sim();
		$display("checks %0d fails %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		#400000;
		fails++;
		end_sim();
	end

	initial begin
		col = 0;
		blank = 1;
		hdir = 0;
		vdir = 0;
		mode = 1;
		q = 0;
		lft = 0;
		rgt = 2071;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		foreach (rdTable[i]) rd(rdTable[i][15:8], rdTable[i][7:0]);
		video_source_model_i.sendWord(102'h38 << 42, 1'b1);
		rd(8'h04, 8'h01);
		frame(2);
		$display("test reset and blank done");
		wr(8'h01, 8'h06);
		rd(8'h01, 8'h06);
		blank = 0;
		hdir = 1;
		vdir = 1;
		frame(3);
		wr(8'h01, 8'h00);
		hdir = 0;
		vdir = 0;
		frame(2);
		$display("test scan direction done");
		wr(8'h10, 8'h64);
		wr(8'h11, 8'h00);
		wr(8'h12, 8'h10);
		wr(8'h13, 8'h00);
		rd(8'h04, 8'h03);
		repeat (70) @(posedge ref_clk);
		rd(8'h04, 8'h01);
		lft = 100;
		rgt = 611;
		frame(129);
		$display("test window done");
		for (int m = 0; m < 4; m++) begin
			if (m == 1)
				continue;
			mode = m;
			wr(8'h00, m[7:0]);
			rd(8'h00, m[7:0]);
			frame(2);
		end
		mode = 1;
		wr(8'h00, 8'h01);
		$display("test input modes done");
		wr(8'h1a, 8'h10);
		wr(8'h03, 8'h40);
		rd(8'h03, 8'h40);
		repeat (70) @(posedge ref_clk);
		q = 1;
		lft = 16;
		rgt = 1039;
		frame(3);
		$display("test quadrupling done");
		end_sim();
	end
endmodule // video_lane_receiver_window_ctrl_bench
